// ==== core/tpsp_port.sv ====
// three pin port with serial pin select and register slave
// Function
// - data register keeps one output bit per pin in bits 2 to 0
// - direction 1: data read returns the latched bit
// - direction 0: data read returns the live pin level
// - direction 1 drives latched data, except that pin 2 releases a one while mode bit 0 is set; direction 0 turns driver off
// - direction and data drive the pin only while it is general i/o; direction still gates the pull-up
// - direction register is write-only and reads as all ones
// - pull-up on only when direction is 0 and pull bit is 1
// - bits 7 to 3 of data, pull-up and select read 0, unwritable
// - reset clears data, direction, pull-up and select registers
// - select bit 2 puts serial data output on pin 2
// - select bit 1 feeds pin 1 to serial data input
// - select bit 0 makes pin 0 the two-way serial clock
// - mode bit 2 hands neighbour pin 2 to the transmit output
// - mode bit 0 makes serial output pin open-drain
// - mode register resets to f8, bits 7..3 read 1, bit 1 reads 0
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module tpsp_port (
   // clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       rst_n,
   // avalon-mm slave
   input  wire logic [tpsp_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [3:0]                 avs_byteenable,
   input  wire logic [tpsp_pkg::DATA_W-1:0] avs_writedata,
   output logic [tpsp_pkg::DATA_W-1:0]     avs_readdata,
   output logic                            avs_waitrequest,
   // port pins
   input  wire logic [tpsp_pkg::PORT_W-1:0] pin_in,
   output logic [tpsp_pkg::PORT_W-1:0]     pin_out,
   output logic [tpsp_pkg::PORT_W-1:0]     pin_oe,
   output logic [tpsp_pkg::PORT_W-1:0]     pin_pullup,
   // clocked serial unit
   input  wire logic                       ser_data_out,
   input  wire logic                       ser_clk_out,
   input  wire logic                       ser_clk_oe,
   output logic                            ser_data_in,
   output logic                            ser_clk_in,
   // neighbour port transmit pin
   output logic                            txd_pin_select
);
   import tpsp_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [PORT_W-1:0] data_q, data_d;
   logic [PORT_W-1:0] dir_q, dir_d;
   logic [PORT_W-1:0] pull_q, pull_d;
   logic [PORT_W-1:0] sel_q, sel_d;
   logic              txd_q, txd_d;
   logic              od_q, od_d;
   logic [7:0]        rdata_d;
   logic [DATA_W-1:0] readdata_q;
   logic              ser_data_in_q, ser_data_in_d;
   logic              ser_clk_in_q, ser_clk_in_d;
   logic              load;
   logic              commit;
   logic              lane0;
   logic              aligned;
   logic [15:0]       idx;
   logic [7:0]        wbyte;
   logic [7:0]        mode7_rd;
   logic [PORT_W-1:0] port_rd;
   logic [PORT_W-1:0] fn_out;
   logic [PORT_W-1:0] fn_oe;

   ////////////////////////////////////////////////////////////////////////
   // bus handshake
   tpsp_bus_slave u_bus (
      .sys_clk       (sys_clk),
      .rst_n         (rst_n),
      .req_read      (avs_read),
      .req_write     (avs_write),
      .waitrequest_q (avs_waitrequest),
      .load          (load),
      .commit        (commit)
   );

   ////////////////////////////////////////////////////////////////////////
   // register access
   always_comb begin
      idx      = avs_address[ADDR_W-1:2];
      aligned  = avs_address[1:0] == ALIGN_ZERO;
      lane0    = avs_byteenable[0];
      wbyte    = avs_writedata[7:0];
      port_rd  = (dir_q & data_q) | (~dir_q & pin_in);
      mode7_rd = MODE7_FIXED | (MODE7_MASK & {LOW_PAD, txd_q, 1'b0, od_q});
      data_d   = data_q;
      dir_d    = dir_q;
      pull_d   = pull_q;
      sel_d    = sel_q;
      txd_d    = txd_q;
      od_d     = od_q;
      rdata_d  = 8'h00;
      if (aligned && idx == IDX_DATA) begin
         rdata_d = {LOW_PAD, port_rd};
      end else if (aligned && idx == IDX_DIR) begin
         rdata_d = DIR_READ;
      end else if (aligned && idx == IDX_PULL) begin
         rdata_d = {LOW_PAD, pull_q};
      end else if (aligned && idx == IDX_SEL) begin
         rdata_d = {LOW_PAD, sel_q};
      end else if (aligned && idx == IDX_MODE7) begin
         rdata_d = mode7_rd;
      end
      if (commit && avs_write && lane0 && aligned) begin
         if (idx == IDX_DATA) begin
            data_d = wbyte[PORT_W-1:0];
         end else if (idx == IDX_DIR) begin
            dir_d = wbyte[PORT_W-1:0];
         end else if (idx == IDX_PULL) begin
            pull_d = wbyte[PORT_W-1:0];
         end else if (idx == IDX_SEL) begin
            sel_d = wbyte[PORT_W-1:0];
         end else if (idx == IDX_MODE7) begin
            txd_d = wbyte[M7_TXD_BIT];
            od_d  = wbyte[M7_OD_BIT];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         data_q     <= PORT_RESET;
         dir_q      <= PORT_RESET;
         pull_q     <= PORT_RESET;
         sel_q      <= PORT_RESET;
         txd_q      <= MODE7_RESET[M7_TXD_BIT];
         od_q       <= MODE7_RESET[M7_OD_BIT];
         readdata_q <= '0;
      end else begin
         data_q <= data_d;
         dir_q  <= dir_d;
         pull_q <= pull_d;
         sel_q  <= sel_d;
         txd_q  <= txd_d;
         od_q   <= od_d;
         if (load && avs_read) begin
            readdata_q <= {WORD_PAD, rdata_d};
         end
      end
   end

   assign avs_readdata = readdata_q;

   ////////////////////////////////////////////////////////////////////////
   // serial function routing
   always_comb begin
      fn_out              = '0;
      fn_oe               = '0;
      fn_out[SEL_SO_BIT]  = ser_data_out;
      fn_oe[SEL_SO_BIT]   = 1'b1;
      fn_out[SEL_SCK_BIT] = ser_clk_out;
      fn_oe[SEL_SCK_BIT]  = ser_clk_oe;
      ser_data_in_d       = sel_q[SEL_SI_BIT] ? pin_in[SEL_SI_BIT] : 1'b1;
      ser_clk_in_d        = sel_q[SEL_SCK_BIT] ? pin_in[SEL_SCK_BIT] : 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ser_data_in_q  <= 1'b1;
         ser_clk_in_q   <= 1'b1;
         txd_pin_select <= 1'b0;
      end else begin
         ser_data_in_q  <= ser_data_in_d;
         ser_clk_in_q   <= ser_clk_in_d;
         txd_pin_select <= txd_q;
      end
   end

   assign ser_data_in = ser_data_in_q;
   assign ser_clk_in  = ser_clk_in_q;

   ////////////////////////////////////////////////////////////////////////
   // pin cells
   for (genvar i = 0; i < PORT_W; i++) begin : g_pin
      tpsp_pin_cell u_cell (
         .sys_clk    (sys_clk),
         .rst_n      (rst_n),
         .fn_select  (sel_q[i]),
         .dir        (dir_q[i]),
         .data       (data_q[i]),
         .pull       (pull_q[i]),
         .open_drain (od_q && (i == SEL_SO_BIT)),
         .fn_out     (fn_out[i]),
         .fn_oe      (fn_oe[i]),
         .pad_out_q  (pin_out[i]),
         .pad_oe_q   (pin_oe[i]),
         .pullup_q   (pin_pullup[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_dir_reads_ones: assert property (@(posedge sys_clk) disable iff (!rst_n)
      load && avs_read && aligned && idx == IDX_DIR
      |=> avs_readdata == {WORD_PAD, DIR_READ})
      else $error("direction register read not all ones");
   a_data_read_mix: assert property (@(posedge sys_clk) disable iff (!rst_n)
      load && avs_read && aligned && idx == IDX_DATA
      |=> avs_readdata[PORT_W-1:0] ==
          (($past(dir_q) & $past(data_q)) | (~$past(dir_q) & $past(pin_in))))
      else $error("data read does not mix latch and pin by direction");
   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      load && avs_read && aligned
      && (idx == IDX_DATA || idx == IDX_PULL || idx == IDX_SEL)
      |=> avs_readdata[7:PORT_W] == LOW_PAD)
      else $error("reserved bits not read as zero");
   a_mode7_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
      load && avs_read && aligned && idx == IDX_MODE7
      |=> (avs_readdata[7:0] & ~MODE7_MASK) == MODE7_FIXED)
      else $error("mode register reserved bits wrong");
   a_reset_clear: assert property (@(posedge sys_clk)
      !rst_n |=> data_q == PORT_RESET && dir_q == PORT_RESET
      && pull_q == PORT_RESET && sel_q == PORT_RESET && !od_q && !txd_q)
      else $error("registers not cleared by reset");
   a_so_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
      sel_q[SEL_SO_BIT] && !od_q ##1 $stable(sel_q) && $stable(od_q)
      |-> pin_oe[SEL_SO_BIT] && pin_out[SEL_SO_BIT] == $past(ser_data_out))
      else $error("serial output not on pin 2");
   a_open_drain: assert property (@(posedge sys_clk) disable iff (!rst_n)
      od_q && sel_q[SEL_SO_BIT] && ser_data_out
      |=> !pin_oe[SEL_SO_BIT])
      else $error("open-drain pin drives high");
   a_write_commit: assert property (@(posedge sys_clk) disable iff (!rst_n)
      commit && avs_write && lane0 && aligned && idx == IDX_DIR
      |=> dir_q == $past(wbyte[PORT_W-1:0]))
      else $error("direction write not kept");
endmodule // tpsp_port

// ==== core/tpsp_pkg.sv ====
// constants of the three pin port with serial pin select
package tpsp_pkg;
   localparam int          PORT_W       = 3;
   localparam int          ADDR_W       = 18;
   localparam int          DATA_W       = 32;
   // register indices, byte address is four times the index
   localparam logic [15:0] IDX_DATA     = 16'hffd6;
   localparam logic [15:0] IDX_DIR      = 16'hffe6;
   localparam logic [15:0] IDX_PULL     = 16'hffee;
   localparam logic [15:0] IDX_SEL      = 16'hfffd;
   localparam logic [15:0] IDX_MODE7    = 16'hffff;
   localparam logic [1:0]  ALIGN_ZERO   = 2'h0;
   // reset and read values
   localparam logic [2:0]  PORT_RESET   = 3'h0;
   localparam logic [7:0]  DIR_READ     = 8'hff;
   localparam logic [7:0]  MODE7_RESET  = 8'hf8;
   localparam logic [7:0]  MODE7_FIXED  = 8'hf8;
   localparam logic [7:0]  MODE7_MASK   = 8'h05;
   localparam logic [4:0]  LOW_PAD      = 5'h00;
   localparam logic [23:0] WORD_PAD     = 24'h000000;
   // field positions
   localparam int          SEL_SCK_BIT  = 0;
   localparam int          SEL_SI_BIT   = 1;
   localparam int          SEL_SO_BIT   = 2;
   localparam int          M7_OD_BIT    = 0;
   localparam int          M7_TXD_BIT   = 2;
   // bus handshake states
   typedef enum logic [1:0] {
      TPSP_IDLE = 2'b01,
      TPSP_ACK  = 2'b10
   } tpsp_bus_state_t;
endpackage

// ==== core/tpsp_bus_slave.sv ====
// avalon-mm handshake: one wait cycle, then one answer cycle
`timescale 1ns/1ps
module tpsp_bus_slave (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // request
   input  wire logic req_read,
   input  wire logic req_write,
   // handshake
   output logic      waitrequest_q,
   output logic      load,
   output logic      commit
);
   import tpsp_pkg::*;

   tpsp_bus_state_t state_q, state_d;
   logic            waitrequest_d;

   always_comb begin
      state_d       = state_q;
      waitrequest_d = 1'b1;
      load          = 1'b0;
      commit        = 1'b0;
      case (state_q)
         TPSP_IDLE: begin
            if (req_read || req_write) begin
               load          = 1'b1;
               state_d       = TPSP_ACK;
               waitrequest_d = 1'b0;
            end
         end
         TPSP_ACK: begin
            commit  = 1'b1;
            state_d = TPSP_IDLE;
         end
         default: state_d = TPSP_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q       <= TPSP_IDLE;
         waitrequest_q <= 1'b1;
      end else begin
         state_q       <= state_d;
         waitrequest_q <= waitrequest_d;
      end
   end

   a_wait_one_cycle: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !waitrequest_q |=> waitrequest_q)
      else $error("waitrequest low for more than one cycle");
endmodule // tpsp_bus_slave

// ==== core/tpsp_pin_cell.sv ====
// one port pin: general i/o or handed to a serial function
`timescale 1ns/1ps
module tpsp_pin_cell (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // port settings
   input  wire logic fn_select,
   input  wire logic dir,
   input  wire logic data,
   input  wire logic pull,
   input  wire logic open_drain,
   // serial function drive
   input  wire logic fn_out,
   input  wire logic fn_oe,
   // pad
   output logic      pad_out_q,
   output logic      pad_oe_q,
   output logic      pullup_q
);
   logic pad_out_d;
   logic pad_oe_d;
   logic pullup_d;
   logic drive;

   always_comb begin
      pad_out_d = fn_select ? fn_out : data;
      drive     = fn_select ? fn_oe : dir;
      // high side off: a driven one becomes released
      pad_oe_d  = drive && !(open_drain && pad_out_d);
      pullup_d  = pull && !dir;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pad_out_q <= 1'b0;
         pad_oe_q  <= 1'b0;
         pullup_q  <= 1'b0;
      end else begin
         pad_out_q <= pad_out_d;
         pad_oe_q  <= pad_oe_d;
         pullup_q  <= pullup_d;
      end
   end

   a_pullup_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
      pullup_q |-> $past(pull) && !$past(dir))
      else $error("pull-up on while pin is output or pull bit clear");
   a_gpio_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $past(!fn_select && !open_drain, 1) && $past(rst_n)
      |-> pad_oe_q == $past(dir) && pad_out_q == $past(data))
      else $error("general i/o pin does not follow direction and data");
endmodule // tpsp_pin_cell

// ==== testbench/tpsp_board.sv ====
// board model that drives the three port pins
`timescale 1ns/1ps
module tpsp_board (
   // clock
   input  wire logic       sys_clk,
   // block side of the pads
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe,
   input  wire logic [2:0] pin_pullup,
   // board drivers
   input  wire logic [2:0] ext_val,
   input  wire logic [2:0] ext_en,
   output logic [2:0]      pin_in
);
   logic [2:0] float_q = 3'h0;
   ////////////////////////////////////////////////////////////////////////
   // a floating pin shows a pattern that changes every cycle
   always @(posedge sys_clk) begin
      float_q <= ~float_q;
   end
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (pin_oe[i]) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en[i]) begin
            pin_in[i] = ext_val[i];
         end else begin
            pin_in[i] = pin_pullup[i] ? 1'b1 : float_q[i];
         end
      end
   end
endmodule // tpsp_board

// ==== testbench/tb_top.sv ====
// self-checking bench of the three pin port
`timescale 1ns/1ps
module tb_top;
   import tpsp_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [17:0] avs_address = 18'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [3:0]  avs_byteenable = 4'h1;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, rd;
   logic        avs_waitrequest;
   logic [2:0]  pin_in, pin_out, pin_oe, pin_pullup, dir, lat, pul;
   logic [2:0]  ext_val = 3'h0;
   logic [2:0]  ext_en = 3'h7;
   logic        ser_data_out = 1'b0;
   logic        ser_clk_out = 1'b0;
   logic        ser_clk_oe = 1'b0;
   logic        ser_data_in, ser_clk_in, txd_pin_select;
   int          n_fail = 0;
   int          tests_run = 0;
   int          seed = 32'hb240;
   ////////////////////////////////////////////////////////////////////////
   tpsp_port tpsp_port_i (.sys_clk, .rst_n, .avs_address, .avs_read,
      .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .pin_in, .pin_out, .pin_oe, .pin_pullup,
      .ser_data_out, .ser_clk_out, .ser_clk_oe, .ser_data_in,
      .ser_clk_in, .txd_pin_select);
   tpsp_board tpsp_board_i (.sys_clk, .pin_out, .pin_oe, .pin_pullup,
      .ext_val, .ext_en, .pin_in);
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [15:0] idx,
                      input logic [7:0] wd);
      @(posedge sys_clk);
      avs_address <= {idx, ALIGN_ZERO};
      avs_writedata <= {WORD_PAD, wd};
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic settle;
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   function automatic logic [31:0] exp_rd(input logic [2:0] d, l, p);
      return 32'((d & l) | (~d & p));
   endfunction
   task automatic wrap_up;
      if (n_fail == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      ext_val <= 3'($random(seed));
      bus(1'b0, IDX_DATA, 8'h00);
      chk(rd, 32'(ext_val));
      bus(1'b0, IDX_DIR, 8'h00);
      chk(rd, {WORD_PAD, DIR_READ});
      bus(1'b0, IDX_PULL, 8'h00);
      chk(rd, 32'h0);
      bus(1'b0, IDX_SEL, 8'h00);
      chk(rd, 32'h0);
      bus(1'b0, IDX_MODE7, 8'h00);
      chk(rd, {WORD_PAD, MODE7_RESET});
      chk(32'(pin_oe | pin_pullup), 32'h0);
      for (int k = 0; k < 40; k++) begin
         dir = 3'($random(seed));
         lat = 3'($random(seed));
         pul = 3'($random(seed));
         ext_val <= 3'($random(seed));
         ext_en <= ~pul;
         bus(1'b1, IDX_PULL, {5'($random(seed)), pul});
         bus(1'b1, IDX_DIR, {5'($random(seed)), dir});
         bus(1'b1, IDX_DATA, {5'($random(seed)), lat});
         bus(1'b0, IDX_DATA, 8'h00);
         chk(rd, exp_rd(dir, lat, ext_val | pul));
         bus(1'b0, IDX_PULL, 8'h00);
         chk(rd, 32'(pul));
         @(negedge sys_clk);
         chk(32'(pin_oe), 32'(dir));
         chk(32'(pin_out & dir), 32'(lat & dir));
         chk(32'(pin_pullup), 32'(pul & ~dir));
      end
      avs_byteenable <= 4'h0;
      bus(1'b1, IDX_PULL, {5'h00, ~pul});
      avs_byteenable <= 4'h1;
      bus(1'b0, IDX_PULL, 8'h00);
      chk(rd, 32'(pul));
      bus(1'b0, 16'hffd0, 8'h00);
      chk(rd, 32'h0);
      bus(1'b1, IDX_DIR, 8'h00);
      bus(1'b1, IDX_SEL, 8'hff);
      bus(1'b0, IDX_SEL, 8'h00);
      chk(rd, 32'h7);
      ext_en <= 3'h3;
      for (int k = 0; k < 8; k++) begin
         ser_data_out <= k[2];
         ser_clk_out <= k[1];
         ser_clk_oe <= k[0];
         ext_val <= 3'($random(seed));
         settle();
         chk(32'({pin_oe[2], pin_out[2]}), 32'({1'b1, k[2]}));
         chk(32'(ser_data_in), 32'(ext_val[1]));
         chk(32'(pin_oe[0]), 32'(k[0]));
         chk(32'(ser_clk_in), 32'(k[0] ? k[1] : ext_val[0]));
      end
      bus(1'b1, IDX_MODE7, 8'h07);
      bus(1'b0, IDX_MODE7, 8'h00);
      chk(rd, 32'hfd);
      for (int k = 0; k < 2; k++) begin
         ser_data_out <= k[0];
         settle();
         chk(32'({txd_pin_select, pin_oe[2]}), 32'({1'b1, ~k[0]}));
      end
      bus(1'b1, IDX_MODE7, 8'h00);
      settle();
      chk(32'(txd_pin_select), 32'h0);
      bus(1'b1, IDX_DIR, 8'h07);
      rst_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      bus(1'b0, IDX_SEL, 8'h00);
      chk(rd, 32'h0);
      @(negedge sys_clk);
      chk(32'(pin_oe), 32'h0);
      wrap_up();
   end
endmodule // tb_top
